/* File: tb/cas_regfile_model.sv */
// Working register file model fed by the datapath write-back
module cas_regfile_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Write-back from the datapath
  input wire logic resValid,
  input wire logic [15:0] result,
  input wire logic divDone,
  input wire logic [15:0] quotientReg,
  input wire logic [15:0] remainderReg,
  // Register view
  output logic [15:0] wreg [0:2]
);
  timeunit 1ns;
  timeprecision 1ns;
  // Divide answers land in fixed slots; other results go to slot 2 unless a divide is done that cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wreg <= '{default: 16'h0000};
    end else if (divDone) begin
      wreg[0] <= quotientReg;
      wreg[1] <= remainderReg;
    end else if (resValid) begin
      wreg[2] <= result;
    end
  end
endmodule // cas_regfile_model

/* File: tb/tb_top.sv */
// Self-checking bench for the ALU and status datapath
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, clkEn, opValid, byteMode, useCarry, resValid, prodValid;
  logic divStart, divSigned, divLong, divHold, divBusy, divDone, statusWrEn, controlWrEn;
  logic repeatActive, nestingDisable, levelHighSet, userIntDisable, programWindowEnable;
  cas_pkg::cas_op_e opCode;
  cas_pkg::cas_mul_e mulMode;
  logic [4:0] flagMask;
  logic [15:0] opA, opB, result, divDivisor, quotientReg, remainderReg, statusWrData;
  logic [15:0] controlWrData, statusValue, controlValue;
  logic [31:0] product, divDividend;
  logic [3:0] cpuLevel;
  logic [15:0] wreg [0:2];
  int errCount = 0;
  int checkCount = 0;
  int n;
  // ==========================================================
  // Operation table: add, subtract, byte, carry chain, masked, shifts
  cas_pkg::cas_op_e tOp [10] = '{cas_pkg::OP_ADD, cas_pkg::OP_SUB, cas_pkg::OP_ADD,
    cas_pkg::OP_AND, cas_pkg::OP_ADD, cas_pkg::OP_ADD, cas_pkg::OP_ADD, cas_pkg::OP_SHRA,
    cas_pkg::OP_SHRL, cas_pkg::OP_SHL};
  // Bit i of these flags belongs to table row i
  logic [9:0] tByte = 10'h004;
  logic [9:0] tCarry = 10'h070;
  logic [4:0] tMask [10] = '{5'h1f, 5'h1f, 5'h1f, 5'h00, 5'h1f, 5'h1f, 5'h1f, 5'h00, 5'h00,
    5'h00};
  logic [15:0] tA [10] = '{16'h7fff, 16'h0005, 16'h12ff, 16'h00f0, 16'hffff, 16'h0001,
    16'h0000, 16'h8000, 16'h8000, 16'h0001};
  logic [15:0] tB [10] = '{16'h0001, 16'h0005, 16'h0001, 16'h0f00, 16'h0000, 16'h0000,
    16'h0000, 16'h000f, 16'h000f, 16'h000f};
  logic [15:0] tRes [10] = '{16'h8000, 16'h0000, 16'h1200, 16'h0000, 16'h0000, 16'h0002,
    16'h0000, 16'hffff, 16'h0001, 16'h8000};
  logic [15:0] tSt [10] = '{16'h010c, 16'h0103, 16'h0103, 16'h0103, 16'h0103, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};
  // Products of 0xffff by 0xffff in every multiply mode
  logic [31:0] tProd [6] = '{32'h0000_0001, 32'hfffe_0001, 32'hffff_0001, 32'hffff_ffe1,
    32'h001e_ffe1, 32'h0000_fe01};

  cas_alu_core i_dut (.clk, .arst_n, .clkEn, .opValid, .opCode, .byteMode, .useCarry,
    .mulMode, .flagMask, .opA, .opB, .resValid, .result, .prodValid, .product, .divStart,
    .divSigned, .divLong, .divDividend, .divDivisor, .divHold, .divBusy, .divDone,
    .quotientReg, .remainderReg, .statusWrEn, .statusWrData, .controlWrEn, .controlWrData,
    .statusValue, .controlValue, .repeatActive, .nestingDisable, .levelHighSet, .cpuLevel,
    .userIntDisable, .programWindowEnable);
  cas_regfile_model i_rf (.clk, .arst_n, .resValid, .result, .divDone, .quotientReg,
    .remainderReg, .wreg);

  // ==========================================================
  // Clock and shared tasks
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Inputs always move 1 ns after the rising edge, away from sampling
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reportAndStop();
    $display("errors=%0d checks=%0d", errCount, checkCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One idle edge first, so opValid never falls and rises in the same step
  task automatic do_op(cas_pkg::cas_op_e op, logic bm, logic uc, logic [4:0] fm,
                       logic [15:0] a, b);
    step();
    opCode = op;
    byteMode = bm;
    useCarry = uc;
    flagMask = fm;
    opA = a;
    opB = b;
    opValid = 1'b1;
    step();
    opValid = 1'b0;
  endtask
  // Divide with an optional three-cycle hold and one clock-enable gap; n counts edges
  task automatic do_div(logic sg, lg, logic [31:0] dd, logic [15:0] dv, logic frz);
    divSigned = sg;
    divLong = lg;
    divDividend = dd;
    divDivisor = dv;
    divStart = 1'b1;
    step();
    divStart = 1'b0;
    n = 1;
    while (!divDone && n < 40) begin
      divHold = frz && n >= 5 && n < 8;
      clkEn = !(frz && n == 10);
      step();
      n++;
    end
  endtask

  // ==========================================================
  // Watchdog sized well beyond the expected run
  initial begin
    #(3000 * 100);
    errCount++;
    reportAndStop();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {arst_n, opValid, byteMode, useCarry, divStart, divSigned, divLong, divHold} = '0;
    {statusWrEn, controlWrEn, repeatActive, nestingDisable, levelHighSet} = '0;
    clkEn = 1'b1;
    opCode = cas_pkg::OP_PASS;
    mulMode = cas_pkg::MM_SS;
    {flagMask, opA, opB, divDividend, divDivisor, statusWrData, controlWrData} = '0;
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    check({statusValue, controlValue}, 32'h0000_0000);
    for (int i = 0; i < 10; i++) begin
      do_op(tOp[i], tByte[i], tCarry[i], tMask[i], tA[i], tB[i]);
      check({resValid, result}, {1'b1, tRes[i]});
      check(statusValue, tSt[i]);
    end
    for (int m = 0; m < 6; m++) begin
      mulMode = cas_pkg::cas_mul_e'(m);
      do_op(cas_pkg::OP_MUL, 1'b0, 1'b0, 5'h00, 16'hffff, 16'hffff);
      check(prodValid, 1'b1);
      check(product, tProd[m]);
    end
    // Divides: plain timing, then a frozen run
    do_div(1'b0, 1'b1, 32'h0001_0000, 16'h0002, 1'b0);
    check(n, 19);
    check({quotientReg, remainderReg}, 32'h8000_0000);
    step();
    check({wreg[0], wreg[1]}, 32'h8000_0000);
    check(divBusy, 1'b0);
    do_div(1'b1, 1'b0, 32'h0000_fff9, 16'h0002, 1'b1);
    check(n, 23);
    check({quotientReg, remainderReg}, 32'hfffd_ffff);
    // Priority level is frozen while nesting is disabled
    nestingDisable = 1'b1;
    statusWrEn = 1'b1;
    statusWrData = 16'h00e0;
    step();
    check(statusValue[7:5], 3'h0);
    nestingDisable = 1'b0;
    step();
    check({cpuLevel, userIntDisable}, {4'h7, 1'b1});
    // Write strobe stays up into the next write
    statusWrData = 16'hffff;
    repeatActive = 1'b1;
    step();
    statusWrEn = 1'b0;
    check(statusValue, 16'h01ff);
    repeatActive = 1'b0;
    // Control: bit 3 only clears by write, set by hardware
    controlWrEn = 1'b1;
    controlWrData = 16'hffff;
    step();
    controlWrEn = 1'b0;
    check({controlValue, programWindowEnable}, {16'h0004, 1'b1});
    levelHighSet = 1'b1;
    step();
    levelHighSet = 1'b0;
    check({controlValue, cpuLevel, userIntDisable}, {16'h000c, 4'hf, 1'b1});
    controlWrEn = 1'b1;
    controlWrData = 16'h0000;
    step();
    controlWrEn = 1'b0;
    check({controlValue, programWindowEnable}, {16'h0000, 1'b0});
    reportAndStop();
  end
endmodule // tb_top

/* File: verilog/cas_alu_core.sv */
// ALU, multiplier, shifter, status and control registers of the core
// Function
// - nibble carry out of bit 3 or 7
// - level is control bit over three status bits
// - level field frozen while nesting disabled
// - status bit 4 mirrors repeat loop active
// - negative flag follows result sign
// - wrap flag marks signed overflow
// - zero flag sticky across carry-chained operations
// - carry flag is carry out of msb
// - subtract carries are inverted borrows
// - high level bit clear-only, blocks user interrupts
// - window enable bit read-write, drives output
// - unused bits read zero, reset clears all
// - 16-bit add, subtract, shift, logic unit
// - byte or word operands, any source
// - multiplier supports six signedness and size modes
// - signed or unsigned divide, long or short
// - quotient and remainder to fixed outputs
// - long dividend packed odd-high, even-low
// - one iteration per divisor bit
// - barrel shift up to 15 in one cycle
// - shifts work on register operands only
// - arithmetic right, logical right, left shifts
// - divide takes 19 cycles, freezable anywhere
// - multiply finishes in one cycle
module cas_alu_core (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Operation request from the decoder
  input wire logic opValid,
  input wire cas_pkg::cas_op_e opCode,
  input wire logic byteMode,
  input wire logic useCarry,
  input wire cas_pkg::cas_mul_e mulMode,
  input wire logic [4:0] flagMask,
  input wire logic [15:0] opA,
  input wire logic [15:0] opB,
  // Results towards working registers or memory
  output logic resValid,
  output logic [15:0] result,
  output logic prodValid,
  output logic [31:0] product,
  // Divide request and answer
  input wire logic divStart,
  input wire logic divSigned,
  input wire logic divLong,
  input wire logic [31:0] divDividend,
  input wire logic [15:0] divDivisor,
  input wire logic divHold,
  output logic divBusy,
  output logic divDone,
  output logic [15:0] quotientReg,
  output logic [15:0] remainderReg,
  // Status and control register access
  input wire logic statusWrEn,
  input wire logic [15:0] statusWrData,
  input wire logic controlWrEn,
  input wire logic [15:0] controlWrData,
  output logic [15:0] statusValue,
  output logic [15:0] controlValue,
  // Core-level signals
  input wire logic repeatActive,
  input wire logic nestingDisable,
  input wire logic levelHighSet,
  output logic [3:0] cpuLevel,
  output logic userIntDisable,
  output logic programWindowEnable
);
  logic stCarry, stZero, stWrap, stNeg, stNib, lvlHigh, windowEn;
  logic [2:0] cpuPriorityLevel;
  logic [15:0] next_result;
  logic next_carry, next_nib, next_wrap, next_neg, next_zero;
  logic aluFire, mulFire;
  logic [33:0] next_product;
  cas_div_if dif ();

  // ==========================================================
  // Adder with byte or word carry taps
  function automatic logic [18:0] addFlags(input logic [15:0] a, input logic [15:0] b,
                                           input logic cin, input logic isByte);
    logic [16:0] w;
    logic [8:0] lo;
    logic [4:0] nib;
    logic c, dc, ov;
    w = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    lo = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
    nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    if (isByte) begin
      c = lo[8];
      dc = nib[4];
      ov = (a[7] == b[7]) && (lo[7] != a[7]);
    end else begin
      c = w[16];
      dc = lo[8];
      ov = (a[15] == b[15]) && (w[15] != a[15]);
    end
    return {dc, ov, c, w[15:0]};
  endfunction

  assign aluFire = opValid && (opCode != cas_pkg::OP_MUL);
  assign mulFire = opValid && (opCode == cas_pkg::OP_MUL);

  // ==========================================================
  // Operation datapath; operands may come from registers or memory
  always_comb begin
    logic [18:0] sumOut;
    logic [16:0] shl, shr, sra;
    logic [15:0] raw;
    logic isSub, cin;
    logic [3:0] amt;
    amt = opB[3:0];
    isSub = (opCode == cas_pkg::OP_SUB);
    // Subtract adds the inverse; carry in of 1 unless chaining a borrow
    cin = useCarry ? stCarry : isSub;
    sumOut = addFlags(opA, isSub ? ~opB : opB, cin, byteMode);
    shl = {1'b0, opA} << amt;
    shr = {opA, 1'b0} >> amt;
    sra = 17'($signed({opA, 1'b0}) >>> amt);
    raw = opA;
    next_carry = stCarry;
    next_nib = 1'b0;
    next_wrap = 1'b0;
    case (opCode)
      cas_pkg::OP_ADD, cas_pkg::OP_SUB: begin
        raw = sumOut[15:0];
        next_carry = sumOut[16];
        next_wrap = sumOut[17];
        next_nib = sumOut[18];
      end
      cas_pkg::OP_AND: raw = opA & opB;
      cas_pkg::OP_IOR: raw = opA | opB;
      cas_pkg::OP_XOR: raw = opA ^ opB;
      // Shifts are word-wide; the decoder only routes register operands here
      cas_pkg::OP_SHL: begin
        raw = shl[15:0];
        next_carry = (amt != 4'h0) ? shl[16] : stCarry;
      end
      cas_pkg::OP_SHRL: begin
        raw = shr[16:1];
        next_carry = (amt != 4'h0) ? shr[0] : stCarry;
      end
      cas_pkg::OP_SHRA: begin
        raw = sra[16:1];
        next_carry = (amt != 4'h0) ? sra[0] : stCarry;
      end
      default: raw = opA;
    endcase
    // Byte operations keep the upper byte of the first operand
    next_result = (byteMode && opCode != cas_pkg::OP_SHL && opCode != cas_pkg::OP_SHRL
                   && opCode != cas_pkg::OP_SHRA) ? {opA[15:8], raw[7:0]} : raw;
    next_neg = byteMode ? next_result[7] : next_result[15];
    next_zero = byteMode ? (next_result[7:0] == 8'h00) : (next_result == 16'h0000);
  end

  // Result register and one-cycle valid
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result <= 16'h0000;
      resValid <= 1'b0;
    end else if (clkEn) begin
      resValid <= aluFire;
      if (aluFire) result <= next_result;
    end
  end

  // ==========================================================
  // 17x17 signed multiplier; each mode picks how operands are extended
  always_comb begin
    logic [16:0] ma, mb;
    ma = {opA[15], opA};
    mb = {opB[15], opB};
    case (mulMode)
      cas_pkg::MM_SS: begin
        ma = {opA[15], opA};
        mb = {opB[15], opB};
      end
      cas_pkg::MM_UU: begin
        ma = {1'b0, opA};
        mb = {1'b0, opB};
      end
      cas_pkg::MM_US: begin
        ma = {1'b0, opA};
        mb = {opB[15], opB};
      end
      cas_pkg::MM_SLIT: begin
        ma = {opA[15], opA};
        mb = {12'h000, opB[4:0]};
      end
      cas_pkg::MM_ULIT: begin
        ma = {1'b0, opA};
        mb = {12'h000, opB[4:0]};
      end
      cas_pkg::MM_U8: begin
        ma = {9'h000, opA[7:0]};
        mb = {9'h000, opB[7:0]};
      end
      default: ;
    endcase
    next_product = $signed(ma) * $signed(mb);
  end

  // Product lands one edge after the request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      product <= 32'h0000_0000;
      prodValid <= 1'b0;
    end else if (clkEn) begin
      prodValid <= mulFire;
      if (mulFire) product <= next_product[31:0];
    end
  end

  // ==========================================================
  // Arithmetic flags: a status write lands first, the operation overrides
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {stNib, stNeg, stWrap, stZero, stCarry} <= 5'h00;
    end else if (clkEn) begin
      if (statusWrEn) begin
        stNib <= statusWrData[cas_pkg::ST_NIB];
        stNeg <= statusWrData[cas_pkg::ST_NEG];
        stWrap <= statusWrData[cas_pkg::ST_WRAP];
        stZero <= statusWrData[cas_pkg::ST_ZERO];
        stCarry <= statusWrData[cas_pkg::ST_CARRY];
      end
      if (aluFire) begin
        // Only the flags the decoder names are touched
        if (flagMask[cas_pkg::FM_NIB]) stNib <= next_nib;
        if (flagMask[cas_pkg::ST_NEG]) stNeg <= next_neg;
        if (flagMask[cas_pkg::ST_WRAP]) stWrap <= next_wrap;
        if (flagMask[cas_pkg::ST_CARRY]) stCarry <= next_carry;
        // Chained operations can only clear zero so a multiword zero test works
        if (flagMask[cas_pkg::ST_ZERO]) stZero <= next_zero & (stZero | !useCarry);
      end
    end
  end

  // Priority level field, read-only while nesting is disabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cpuPriorityLevel <= 3'h0;
    else if (clkEn && statusWrEn && !nestingDisable)
      cpuPriorityLevel <= statusWrData[cas_pkg::ST_LVL_HI:cas_pkg::ST_LVL_LO];
  end

  // Control register: high level bit is cleared by software, set by hardware
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lvlHigh <= cas_pkg::CONTROL_RESET[cas_pkg::CC_LVL_HI];
      windowEn <= cas_pkg::CONTROL_RESET[cas_pkg::CC_WINDOW];
    end else if (clkEn) begin
      if (levelHighSet) lvlHigh <= 1'b1;
      else if (controlWrEn && !controlWrData[cas_pkg::CC_LVL_HI]) lvlHigh <= 1'b0;
      if (controlWrEn) windowEn <= controlWrData[cas_pkg::CC_WINDOW];
    end
  end

  // Read views; unused positions are constant zero
  always_comb begin
    statusValue = cas_pkg::STATUS_RESET;
    statusValue[cas_pkg::ST_NIB] = stNib;
    statusValue[cas_pkg::ST_LVL_HI:cas_pkg::ST_LVL_LO] = cpuPriorityLevel;
    statusValue[cas_pkg::ST_RPT] = repeatActive;
    statusValue[cas_pkg::ST_NEG] = stNeg;
    statusValue[cas_pkg::ST_WRAP] = stWrap;
    statusValue[cas_pkg::ST_ZERO] = stZero;
    statusValue[cas_pkg::ST_CARRY] = stCarry;
    controlValue = cas_pkg::CONTROL_RESET;
    controlValue[cas_pkg::CC_LVL_HI] = lvlHigh;
    controlValue[cas_pkg::CC_WINDOW] = windowEn;
  end
  assign cpuLevel = {lvlHigh, cpuPriorityLevel};
  assign userIntDisable = lvlHigh || (cpuPriorityLevel == cas_pkg::LEVEL_TOP);
  assign programWindowEnable = windowEn;

  // ==========================================================
  // Divide engine; hold pauses it for an interrupt without losing state
  assign dif.start = divStart;
  assign dif.signedMode = divSigned;
  assign dif.longMode = divLong;
  assign dif.dividend = divDividend;
  assign dif.divisor = divDivisor;
  assign dif.hold = divHold;
  assign divBusy = dif.busy;
  assign divDone = dif.done;
  assign quotientReg = dif.quotient;
  assign remainderReg = dif.remainder;
  cas_divider u_div (
    .clk(clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .dif(dif)
  );

  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n || !clkEn);
  sequence s_wordAdd;
    opValid && opCode == cas_pkg::OP_ADD && !byteMode && !useCarry && !statusWrEn;
  endsequence
  sequence s_wordSub;
    opValid && opCode == cas_pkg::OP_SUB && !byteMode && !useCarry && !statusWrEn;
  endsequence
  a_nib_word: assert property (s_wordAdd and flagMask[cas_pkg::FM_NIB] |=>
      stNib == (({1'b0, $past(opA[7:0])} + {1'b0, $past(opB[7:0])}) > 9'h0FF))
    else $error("nibble carry wrong for word add");
  a_neg_sign: assert property (aluFire && flagMask[cas_pkg::ST_NEG] |=>
      stNeg == ($past(byteMode) ? result[7] : result[15]))
    else $error("negative flag does not follow result");
  a_wrap_add: assert property (s_wordAdd and flagMask[cas_pkg::ST_WRAP] |=>
      stWrap == ($past(opA[15]) == $past(opB[15]) && result[15] != $past(opA[15])))
    else $error("signed wrap flag wrong");
  a_borrow_sub: assert property (s_wordSub and flagMask[cas_pkg::ST_CARRY] |=>
      stCarry == ($past(opA) >= $past(opB)))
    else $error("borrow polarity wrong");
  a_zero_sticky: assert property (useCarry && !stZero && !statusWrEn |=> !stZero)
    else $error("chained op set zero flag");
  a_keep_carry: assert property (aluFire && !flagMask[cas_pkg::ST_CARRY]
      && !statusWrEn |=> $stable(stCarry))
    else $error("unselected flag changed");
  a_level_lock: assert property (nestingDisable |=> $stable(cpuPriorityLevel))
    else $error("level changed while nesting disabled");
  a_high_clear: assert property (!lvlHigh && !levelHighSet |=> !lvlHigh)
    else $error("software set the high level bit");
  a_level_view: assert property (userIntDisable == (&statusValue[7:5] | controlValue[3]))
    else $error("user interrupt gate wrong");
  a_unused_zero: assert property (statusValue[15:9] == 7'h00
      && controlValue[15:4] == 12'h000 && controlValue[1:0] == 2'h0
      && statusValue[4] == repeatActive)
    else $error("unused bits or repeat view wrong");
  a_mul_one: assert property (mulFire && mulMode == cas_pkg::MM_UU |=>
      prodValid && product == $past(opA) * $past(opB))
    else $error("unsigned product late or wrong");
  a_shift_ar: assert property (aluFire && opCode == cas_pkg::OP_SHRA |=>
      result == 16'($signed($past(opA)) >>> $past(opB[3:0])))
    else $error("arithmetic shift wrong");
endmodule // cas_alu_core

/* File: verilog/cas_div_if.sv */
// Interface between the ALU core and its divide engine
interface cas_div_if;
  logic start, signedMode, longMode, hold, busy, done;
  logic [31:0] dividend;
  logic [15:0] divisor, quotient, remainder;
  modport master (
    output start, signedMode, longMode, hold, dividend, divisor,
    input busy, done, quotient, remainder
  );
  modport slave (
    input start, signedMode, longMode, hold, dividend, divisor,
    output busy, done, quotient, remainder
  );
endinterface

/* File: verilog/cas_divider.sv */
// Iterative divide engine: 19 cycles per divide, freezable at any cycle
module cas_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Request and answer
  cas_div_if.slave dif
);
  cas_pkg::cas_div_state_e state;
  logic [15:0] rem, quo, dvs;
  logic [3:0] iterCnt;
  logic sMode, lMode, negQ, negR;
  logic [16:0] shifted;
  logic [17:0] diff;
  logic [31:0] rawD, absD;
  logic run;

  // Hold freezes every register so an interrupt can slip in and resume
  assign run = clkEn && !dif.hold;
  assign dif.busy = (state != cas_pkg::DS_IDLE);
  assign dif.done = (state == cas_pkg::DS_DONE);
  assign shifted = {rem, quo[15]};
  assign diff = {1'b0, shifted} - {2'b00, dvs};
  // 16-bit dividends are widened by sign or zero as the mode asks
  assign rawD = lMode ? {rem, quo} : {{16{sMode & quo[15]}}, quo};
  assign absD = (sMode && rawD[31]) ? (32'h0000_0000 - rawD) : rawD;

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= cas_pkg::DS_IDLE;
    end else if (run) begin
      case (state)
        cas_pkg::DS_IDLE: if (dif.start) state <= cas_pkg::DS_LOAD;
        cas_pkg::DS_LOAD: state <= cas_pkg::DS_ITER;
        cas_pkg::DS_ITER: begin
          if (iterCnt == 4'(cas_pkg::DIV_BITS - 1)) state <= cas_pkg::DS_FIX;
        end
        cas_pkg::DS_FIX: state <= cas_pkg::DS_DONE;
        cas_pkg::DS_DONE: state <= cas_pkg::DS_IDLE;
        default: state <= cas_pkg::DS_IDLE;
      endcase
    end
  end

  // Datapath: latch, take magnitudes, restoring steps, sign fix-up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rem <= 16'h0000;
      quo <= 16'h0000;
      dvs <= 16'h0000;
      iterCnt <= 4'h0;
      sMode <= 1'b0;
      lMode <= 1'b0;
      negQ <= 1'b0;
      negR <= 1'b0;
    end else if (run) begin
      case (state)
        cas_pkg::DS_IDLE: if (dif.start) begin
          {rem, quo} <= dif.dividend;
          dvs <= dif.divisor;
          sMode <= dif.signedMode;
          lMode <= dif.longMode;
        end
        cas_pkg::DS_LOAD: begin
          {rem, quo} <= absD;
          dvs <= (sMode && dvs[15]) ? (16'h0000 - dvs) : dvs;
          negQ <= sMode && (rawD[31] ^ dvs[15]);
          negR <= sMode && rawD[31];
          iterCnt <= 4'h0;
        end
        cas_pkg::DS_ITER: begin
          // One quotient bit per divisor bit
          if (!diff[17]) begin
            rem <= diff[15:0];
            quo <= {quo[14:0], 1'b1};
          end else begin
            rem <= shifted[15:0];
            quo <= {quo[14:0], 1'b0};
          end
          iterCnt <= iterCnt + 4'h1;
        end
        cas_pkg::DS_FIX: begin
          quo <= negQ ? (16'h0000 - quo) : quo;
          rem <= negR ? (16'h0000 - rem) : rem;
        end
        default: ;
      endcase
    end
  end
  assign dif.quotient = quo;
  assign dif.remainder = rem;

  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [4:0] spanCnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) spanCnt <= 5'h00;
    else if (run && state == cas_pkg::DS_IDLE && dif.start) spanCnt <= 5'h01;
    else if (run && dif.busy) spanCnt <= spanCnt + 5'h01;
  end
  sequence s_launch;
    run && !dif.busy && dif.start;
  endsequence
  a_div_span: assert property (dif.done |-> spanCnt == 5'(cas_pkg::DIV_CYCLES))
    else $error("divide did not finish in 19 active cycles");
  a_div_launch: assert property (s_launch |=> dif.busy && !dif.done)
    else $error("divide start not taken");
endmodule // cas_divider

/* File: verilog/cas_pkg.sv */
// Shared constants and types for the ALU and status datapath
package cas_pkg;
  // ==========================================================
  // Status register field positions
  localparam int ST_CARRY = 0;
  localparam int ST_ZERO = 1;
  localparam int ST_WRAP = 2;
  localparam int ST_NEG = 3;
  localparam int ST_RPT = 4;
  localparam int ST_LVL_LO = 5;
  localparam int ST_LVL_HI = 7;
  localparam int ST_NIB = 8;
  // Flag mask bit for the nibble carry (others share status positions)
  localparam int FM_NIB = 4;
  // ==========================================================
  // Control register field positions
  localparam int CC_WINDOW = 2;
  localparam int CC_LVL_HI = 3;
  // ==========================================================
  // Reset values and top priority level
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [2:0] LEVEL_TOP = 3'h7;
  // ==========================================================
  // Divide timing
  localparam int DIV_BITS = 16;
  localparam int DIV_CYCLES = 19;
  // ==========================================================
  // Operation, multiply mode and divider state types
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_IOR = 4'h3, OP_XOR = 4'h4,
    OP_SHRA = 4'h5, OP_SHRL = 4'h6, OP_SHL = 4'h7, OP_MUL = 4'h8, OP_PASS = 4'h9
  } cas_op_e;
  typedef enum logic [2:0] {
    MM_SS = 3'h0, MM_UU = 3'h1, MM_US = 3'h2, MM_SLIT = 3'h3, MM_ULIT = 3'h4, MM_U8 = 3'h5
  } cas_mul_e;
  typedef enum logic [4:0] {
    DS_IDLE = 5'h01, DS_LOAD = 5'h02, DS_ITER = 5'h04, DS_FIX = 5'h08, DS_DONE = 5'h10
  } cas_div_state_e;
endpackage
